// ---- rtc_core_pkg.sv ----
/*
 * Constants, types and register map for the real-time clock core.
 * Assumes a single 100 MHz clock and host strobes synchronous to it.
 */
package rtc_core_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_MS  = 1000;
  localparam int RST_HOLD_MS   = 40;
  localparam int NS_PER_MS     = 1000000;

  // Register indices
  localparam int          ADDR_W   = 5;
  localparam int          TIME_N   = 8;
  localparam int          ALARM_N  = 4;
  localparam int          IDX_SEC  = 0;
  localparam int          IDX_MIN  = 1;
  localparam int          IDX_HOUR = 2;
  localparam int          IDX_DAY  = 3;
  localparam int          IDX_DATE = 4;
  localparam int          IDX_MON  = 5;
  localparam logic [4:0] A_CENT    = 5'h07;
  localparam logic [4:0] A_AL_SEC  = 5'h08;
  localparam logic [4:0] A_AL_DAY  = 5'h0B;
  localparam logic [4:0] A_FLAGS   = 5'h0E;
  localparam logic [4:0] A_CTRL    = 5'h0F;

  // Field positions
  localparam int MASK_BIT     = 7;
  localparam int DYDT_BIT     = 6;
  localparam int FLG_IRQ      = 7;
  localparam int FLG_WDOG     = 6;
  localparam int FLG_ALARM    = 5;
  localparam int CTRL_TE      = 7;
  localparam int CTRL_OSC_DIS = 6;
  localparam int CTRL_APE     = 1;
  localparam int CTRL_AIE     = 0;

  // Reset values and BCD limits
  localparam logic [7:0] CTRL_RST  = 8'h80;
  localparam logic [7:0] BCD_ZERO  = 8'h00;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] SEC_MAX   = 8'h59;
  localparam logic [7:0] HOUR_MAX  = 8'h23;
  localparam logic [7:0] DAY_MAX   = 8'h07;
  localparam logic [7:0] DATE_MAX  = 8'h31;
  localparam logic [7:0] MON_MAX   = 8'h12;
  localparam logic [7:0] YEAR_MAX  = 8'h99;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // Alarm mask settings {third, second, first}
  localparam logic [2:0] AM_EVERY = 3'h7;
  localparam logic [2:0] AM_SEC   = 3'h6;
  localparam logic [2:0] AM_MIN   = 3'h4;
  localparam logic [2:0] AM_HOUR  = 3'h0;

  typedef enum logic [1:0] {RST_PULL, RST_HOLD, RST_OFF} rst_state_e;

  typedef struct packed {
    logic              cs_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } host_bus_s;

endpackage

// ---- rtc_core.sv ----
/*
 * Real-time clock core: byte-wide host port, power-fail blocking,
 * power-on reset, double-buffered BCD time, time-of-day alarm.
 * Assumes host strobes already synchronous to clk_i and a supply
 * comparator that reports main supply above the fail threshold.
 */
// Functional notes
// - Write when write strobe and select low
// - Write starts at later strobe edge
// - Write strobe low turns data drivers off
// - No access below power-fail threshold
// - Retention floats outputs, memory enable forced high
// - Reset pulled low, held after supply returns
// - Oscillator runs only while disable bit clear
// - Transfer bit clear freezes visible time
// - Frozen registers hold time of halt
// - Updates resume within one second
// - Setting transfer bit loads internal counters
// - Time values BCD, hours 24-hour form
// - Alarm registers sit at 08h to 0Bh
// - Mask bits select alarm rate
// - Day/date select adds day or date match
// - Undefined mask falls back to every second
// - Matching enabled fields set alarm flag
// - Interrupt driven only with irq enable
// - Power-on output driven only with enable
// - Alarm compare keeps working on battery
// - Read mode drives bus while output enabled
// - Flag register read clears flags, releases irq
`timescale 1ns/10ps
module rtc_core
  import rtc_core_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter int HOLD_CYCLES = RST_HOLD_MS * (NS_PER_MS / CLK_PERIOD_NS)
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Host port
  input  wire host_bus_s  host_i,
  output logic [7:0]      data_o,
  output logic            data_oe_o,
  // Supply and memory enable
  input  wire logic       main_supply_ok_i,
  input  wire logic       ext_mem_enable_in_n_i,
  output logic            ext_mem_enable_out_n_o,
  // Open-drain outputs, enable high pulls low
  output logic            reset_oe_o,
  output logic            irq_oe_o,
  output logic            power_on_out_n_oe_o
);

  ////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
    if (v >= hi) begin
      return {1'b1, lo};
    end else if (v[3:0] >= DIGIT_MAX) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      return {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic [7:0] lim_hi(input int i);
    case (i)
      IDX_SEC, IDX_MIN: return SEC_MAX;
      IDX_HOUR:         return HOUR_MAX;
      IDX_DAY:          return DAY_MAX;
      IDX_DATE:         return DATE_MAX;
      IDX_MON:          return MON_MAX;
      default:          return YEAR_MAX;
    endcase
  endfunction

  function automatic logic [7:0] lim_lo(input int i);
    if (i == IDX_DAY || i == IDX_DATE || i == IDX_MON) begin
      return BCD_ONE;
    end else begin
      return BCD_ZERO;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  logic [7:0]          tm       [TIME_N];
  logic [7:0]          next_tm  [TIME_N];
  logic [7:0]          vis      [TIME_N];
  logic [7:0]          al       [ALARM_N];
  logic [TIME_N-1:0]   cy;
  logic [8:0]          inc;
  logic                cin;
  logic                te;
  logic                osc_dis;
  logic                aie;
  logic                ape;
  logic                alarm_flag;
  logic                irq_flag;
  logic                wr_act;
  logic                wr_act_q;
  logic                wr_end;
  logic [ADDR_W-1:0]   wr_addr;
  logic [7:0]          wr_data;
  logic                rd_act;
  logic                rd_flags;
  logic                rd_flags_q;
  logic                flag_clr;
  logic                te_rise;
  logic [31:0]         tick_cnt;
  logic                tick;
  logic                tick_q;
  logic [2:0]          am;
  logic                m_sec;
  logic                m_min;
  logic                m_hour;
  logic                m_dd;
  logic                hit;
  rst_state_e          rst_state;
  logic [31:0]         hold_cnt;

  ////////////////////////////////////////////////////////////////////
  // Host cycle decode; nothing is accepted below the fail threshold
  assign wr_act   = main_supply_ok_i & ~host_i.cs_n & ~host_i.we_n;
  assign rd_act   = main_supply_ok_i & ~host_i.cs_n & host_i.we_n & ~host_i.oe_n;
  assign wr_end   = wr_act_q & ~wr_act & main_supply_ok_i;
  assign rd_flags = rd_act & (host_i.addr == A_FLAGS);
  // Flags drop once the flag read ends: address change, or select/enable rise
  assign flag_clr = rd_flags_q & ~rd_flags;
  assign te_rise  = wr_end & (wr_addr == A_CTRL) & wr_data[CTRL_TE] & ~te;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_act_q   <= 1'b0;
      wr_addr    <= '0;
      wr_data    <= '0;
      rd_flags_q <= 1'b0;
    end else begin
      wr_act_q   <= wr_act;
      rd_flags_q <= rd_flags;
      // Address taken at the later falling strobe, data until the end
      if (wr_act && !wr_act_q) begin
        wr_addr <= host_i.addr;
      end
      if (wr_act) begin
        wr_data <= host_i.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      te      <= CTRL_RST[CTRL_TE];
      osc_dis <= CTRL_RST[CTRL_OSC_DIS];
      aie     <= CTRL_RST[CTRL_AIE];
      ape     <= CTRL_RST[CTRL_APE];
    end else if (wr_end && wr_addr == A_CTRL) begin
      te      <= wr_data[CTRL_TE];
      osc_dis <= wr_data[CTRL_OSC_DIS];
      aie     <= wr_data[CTRL_AIE];
      ape     <= wr_data[CTRL_APE];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // One-second time base; stops dead while the oscillator is disabled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
      tick_q   <= 1'b0;
    end else begin
      tick_q <= tick;
      if (osc_dis) begin
        tick_cnt <= '0;
        tick     <= 1'b0;
      end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
        tick     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // BCD carry chain; day and date both advance on the hour carry
  always_comb begin
    cy  = '0;
    inc = '0;
    cin = 1'b0;
    for (int i = 0; i < TIME_N; i++) begin
      next_tm[i] = tm[i];
      if (i == IDX_SEC) begin
        cin = 1'b1;
      end else if (i == IDX_DATE) begin
        cin = cy[IDX_HOUR];
      end else begin
        cin = cy[i-1];
      end
      inc = bcd_inc(tm[i], lim_lo(i), lim_hi(i));
      if (cin) begin
        next_tm[i] = inc[7:0];
        cy[i]      = inc[8];
      end
    end
  end

  // Internal counters: load and increment share one process, so a
  // transfer never lands in the middle of an increment
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < TIME_N; i++) begin
        tm[i] <= lim_lo(i);
      end
    end else if (te_rise) begin
      tm <= vis;
    end else if (tick) begin
      tm <= next_tm;
    end
  end

  // Visible copy follows the counters only while transfer is enabled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < TIME_N; i++) begin
        vis[i] <= lim_lo(i);
      end
    end else if (wr_end && wr_addr <= A_CENT) begin
      vis[wr_addr[2:0]] <= wr_data;
    end else if (te) begin
      vis <= tm;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Alarm registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ALARM_N; i++) begin
        al[i] <= BCD_ZERO;
      end
    end else if (wr_end && wr_addr >= A_AL_SEC && wr_addr <= A_AL_DAY) begin
      al[wr_addr[1:0]] <= wr_data;
    end
  end

  // Compared against the internal counters, so it runs on battery too
  assign am     = {al[2][MASK_BIT], al[1][MASK_BIT], al[0][MASK_BIT]};
  assign m_sec  = tm[IDX_SEC] == {1'b0, al[0][6:0]};
  assign m_min  = tm[IDX_MIN] == {1'b0, al[1][6:0]};
  assign m_hour = tm[IDX_HOUR] == {1'b0, al[2][6:0]};
  assign m_dd   = al[3][MASK_BIT] ? 1'b1 :
                  al[3][DYDT_BIT] ? tm[IDX_DAY] == {2'h0, al[3][5:0]} :
                                    tm[IDX_DATE] == {2'h0, al[3][5:0]};

  always_comb begin
    case (am)
      AM_SEC:  hit = m_sec;
      AM_MIN:  hit = m_sec & m_min;
      AM_HOUR: hit = m_sec & m_min & m_hour & m_dd;
      // Any other setting is treated as every second
      default: hit = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Flags: checked once per increment; a set beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alarm_flag <= 1'b0;
      irq_flag   <= 1'b0;
    end else begin
      if (tick_q && hit) begin
        alarm_flag <= 1'b1;
      end else if (flag_clr) begin
        alarm_flag <= 1'b0;
      end
      if (tick_q && hit && aie) begin
        irq_flag <= 1'b1;
      end else if (flag_clr) begin
        irq_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path and data drivers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_o    <= '0;
      data_oe_o <= 1'b0;
    end else begin
      // Write strobe low takes the drivers off the bus
      data_oe_o <= rd_act;
      if (host_i.addr <= A_CENT) begin
        data_o <= vis[host_i.addr[2:0]];
      end else if (host_i.addr >= A_AL_SEC && host_i.addr <= A_AL_DAY) begin
        data_o <= al[host_i.addr[1:0]];
      end else if (host_i.addr == A_FLAGS) begin
        data_o <= '0;
        data_o[FLG_IRQ]   <= irq_flag;
        data_o[FLG_ALARM] <= alarm_flag;
      end else if (host_i.addr == A_CTRL) begin
        data_o <= '0;
        data_o[CTRL_TE]      <= te;
        data_o[CTRL_OSC_DIS] <= osc_dis;
        data_o[CTRL_AIE]     <= aie;
        data_o[CTRL_APE]     <= ape;
      end else begin
        data_o <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt floats in retention; power-on and memory enable do not
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_oe_o               <= 1'b0;
      power_on_out_n_oe_o    <= 1'b0;
      ext_mem_enable_out_n_o <= 1'b1;
    end else begin
      irq_oe_o               <= irq_flag & aie & main_supply_ok_i;
      power_on_out_n_oe_o    <= alarm_flag & ape;
      ext_mem_enable_out_n_o <= ext_mem_enable_in_n_i | ~main_supply_ok_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power-on reset: pull while supply low, hold once it returns
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_state  <= RST_PULL;
      hold_cnt   <= '0;
      reset_oe_o <= 1'b1;
    end else begin
      case (rst_state)
        RST_PULL: begin
          hold_cnt   <= '0;
          reset_oe_o <= 1'b1;
          if (main_supply_ok_i) begin
            rst_state <= RST_HOLD;
          end
        end
        RST_HOLD: begin
          reset_oe_o <= 1'b1;
          hold_cnt   <= hold_cnt + 32'h1;
          if (!main_supply_ok_i) begin
            rst_state <= RST_PULL;
          end else if (hold_cnt >= 32'(HOLD_CYCLES - 1)) begin
            rst_state  <= RST_OFF;
            reset_oe_o <= 1'b0;
          end
        end
        RST_OFF: begin
          reset_oe_o <= ~main_supply_ok_i;
          if (!main_supply_ok_i) begin
            rst_state <= RST_PULL;
          end
        end
        default: begin
          rst_state  <= RST_PULL;
          reset_oe_o <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  property p_write_alarm;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_end && wr_addr == A_AL_SEC) |=> (al[0] == $past(wr_data));
  endproperty
  a_write_alarm: assert property (p_write_alarm) else $error("alarm write lost");

  property p_we_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!host_i.we_n && !host_i.cs_n) |=> !data_oe_o;
  endproperty
  a_we_off: assert property (p_we_off) else $error("driving during write");

  property p_read_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
      (main_supply_ok_i && !host_i.cs_n && !host_i.oe_n && host_i.we_n) |=> data_oe_o;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");

  property p_pf_block;
    @(posedge clk_i) disable iff (!rst_n_i)
      !main_supply_ok_i |=> (!data_oe_o && !irq_oe_o);
  endproperty
  a_pf_block: assert property (p_pf_block) else $error("access in power fail");

  property p_rst_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(main_supply_ok_i) |=> reset_oe_o [*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset released early");

  property p_osc_stop;
    @(posedge clk_i) disable iff (!rst_n_i)
      osc_dis |=> !tick;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("tick while stopped");

  property p_freeze;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!te && !wr_end) |=> $stable(vis[IDX_SEC]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("visible time moved");

  property p_load;
    @(posedge clk_i) disable iff (!rst_n_i)
      te_rise |=> (tm[IDX_SEC] == $past(vis[IDX_SEC]));
  endproperty
  a_load: assert property (p_load) else $error("transfer did not load");

  property p_alarm_set;
    @(posedge clk_i) disable iff (!rst_n_i)
      (tick_q && hit) |=> alarm_flag;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag missed");

  property p_irq_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
      irq_oe_o |-> ($past(aie) && $past(irq_flag));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_pwr_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
      power_on_out_n_oe_o |-> ($past(ape) && $past(alarm_flag));
  endproperty
  a_pwr_gate: assert property (p_pwr_gate) else $error("power-on without enable");

endmodule

// ---- host_cpu_model.sv ----
/*
 * Host CPU model for the clock core's byte-wide strobe port.
 * Assumes a single clock; strobes change 1 ns after a rising edge.
 */
`timescale 1ns/10ps
module host_cpu_model
  import rtc_core_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Bus towards the device
  output host_bus_s       host_o,
  input  wire logic [7:0] data_i,
  input  wire logic       data_oe_i
);
  bit tmo;
  bit oe_seen;
  bit oe_after;

  initial begin
    host_o = {3'b111, 5'h00, 8'h00};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write, optionally read-overlapped or strobe-first
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input bit oe_low,
                    input bit we_first);
    @(posedge clk_i);
    #1;
    if (we_first) begin
      host_o.we_n = 1'b0;
      host_o.addr = a ^ 5'h01;
      @(posedge clk_i);
      #1;
    end
    if (oe_low) begin
      host_o.cs_n = 1'b0;
      host_o.oe_n = 1'b0;
      host_o.addr = a;
      repeat (2) @(posedge clk_i);
      #1;
      oe_seen = data_oe_i;
    end
    host_o.addr  = a;
    host_o.wdata = d;
    host_o.cs_n  = 1'b0;
    host_o.we_n  = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    oe_after     = data_oe_i;
    host_o.cs_n  = 1'b1;
    host_o.we_n  = 1'b1;
    host_o.oe_n  = 1'b1;
    // Released lines show garbage, never the old value
    host_o.wdata = ~d;
    host_o.addr  = ~a;
    @(posedge clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read, data taken once the output enable is seen
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    int n;
    host_o.addr = a;
    host_o.cs_n = 1'b0;
    host_o.oe_n = 1'b0;
    host_o.we_n = 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (data_oe_i !== 1'b1 && n < 4);
    tmo = (data_oe_i !== 1'b1);
    d = tmo ? 8'hXX : data_i;
    host_o.cs_n = 1'b1;
    host_o.oe_n = 1'b1;
    host_o.addr = ~a;
    // One idle edge so a following call never flips a strobe in this step
    @(posedge clk_i);
    #1;
  endtask
endmodule

// ---- testbench.sv ----
/*
 * Self-checking bench for the clock core, host model on the strobe port.
 * Assumes short tick and reset-hold parameters so the run stays brief.
 */
`timescale 1ns/10ps
module testbench;
  import rtc_core_pkg::*;
  localparam int TICK = 20;
  localparam int HOLD = 12;
  logic       clk_i;
  logic       rst_n_i;
  logic       main_supply_ok_i;
  logic       ext_mem_enable_in_n_i;
  host_bus_s  host_i;
  logic [7:0] data_o;
  logic       data_oe_o;
  logic       ext_mem_enable_out_n_o;
  logic       reset_oe_o;
  logic       irq_oe_o;
  logic       power_on_out_n_oe_o;
  int         error_cnt;
  int         checks_done;
  logic [7:0] rv;
  logic [7:0] s0;
  logic [7:0] t_wrap [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0] t_next [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

  rtc_core #(.TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .host_i(host_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .main_supply_ok_i(main_supply_ok_i),
    .ext_mem_enable_in_n_i(ext_mem_enable_in_n_i),
    .ext_mem_enable_out_n_o(ext_mem_enable_out_n_o), .reset_oe_o(reset_oe_o),
    .irq_oe_o(irq_oe_o), .power_on_out_n_oe_o(power_on_out_n_oe_o));

  host_cpu_model host (.clk_i(clk_i), .host_o(host_i), .data_i(data_o),
                       .data_oe_i(data_oe_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task rdv(input logic [4:0] a);
    host.rd(a, rv);
    if (host.tmo) begin
      error_cnt++;
      $display("ERROR %0t: read not answered", $time);
      end_of_test();
    end
  endtask

  task put(input logic [4:0] a, input logic [7:0] d);
    host.wr(a, d, 1'b0, 1'b0);
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  function automatic logic sig(input int s);
    return (s == 0) ? irq_oe_o : (s == 1) ? reset_oe_o : power_on_out_n_oe_o;
  endfunction

  // Bounded wait; an expired wait ends the run
  task automatic wait_on(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (sig(s) !== v) begin
      error_cnt++;
      $display("ERROR %0t: wait expired", $time);
      end_of_test();
    end
  endtask

  task automatic wait_chg(input logic [7:0] old);
    int n;
    n = 0;
    rdv(5'h00);
    while (rv === old && n < 40) begin
      rdv(5'h00);
      n++;
    end
    if (rv === old) begin
      error_cnt++;
      $display("ERROR %0t: time did not advance", $time);
      end_of_test();
    end
  endtask

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v == SEC_MAX)
      return BCD_ZERO;
    return (v[3:0] == DIGIT_MAX) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    rst_n_i = 1'b0;
    main_supply_ok_i = 1'b1;
    ext_mem_enable_in_n_i = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    wt(1);
    chk({7'h00, reset_oe_o}, 8'h01);
    wt(HOLD - 4);
    chk({7'h00, reset_oe_o}, 8'h01);
    wait_on(1, 1'b0, 8);
    chk({7'h00, ext_mem_enable_out_n_o}, 8'h00);
    rdv(A_CTRL);
    chk(rv, CTRL_RST);
    // Write opened by strobe first, select later
    host.wr(5'h09, 8'h45, 1'b0, 1'b1);
    rdv(5'h09);
    chk(rv, 8'h45);
    rdv(5'h08);
    chk(rv, 8'h00);
    host.wr(5'h08, 8'h3C, 1'b1, 1'b0);
    chk({7'h00, host.oe_seen}, 8'h01);
    chk({7'h00, host.oe_after}, 8'h00);
    rdv(5'h08);
    chk(rv, 8'h3C);
    // Load end of year with the oscillator stopped
    put(A_CTRL, 8'h40);
    for (int i = 0; i < 7; i++)
      put(i[4:0], t_wrap[i]);
    put(A_CTRL, 8'hC0);
    wt(3 * TICK);
    rdv(5'h00);
    chk(rv, 8'h59);
    put(A_CTRL, 8'h80);
    wait_chg(8'h59);
    chk(rv, 8'h00);
    for (int i = 1; i < 7; i++) begin
      rdv(i[4:0]);
      chk(rv, t_next[i]);
    end
    // Freeze, then release through a transfer
    put(A_CTRL, 8'h00);
    rdv(5'h00);
    s0 = rv;
    wt(3 * TICK);
    rdv(5'h00);
    chk(rv, s0);
    put(A_CTRL, 8'h80);
    wait_chg(s0);
    chk(rv, bcd_inc(s0));
    // Seconds match with both outputs enabled
    put(A_CTRL, 8'h40);
    put(5'h00, 8'h00);
    put(A_CTRL, 8'hC0);
    put(A_AL_SEC, 8'h02);
    put(5'h09, 8'h80);
    put(5'h0A, 8'h80);
    put(A_AL_DAY, 8'h80);
    put(A_CTRL, 8'h83);
    wait_on(0, 1'b1, 4 * TICK);
    chk({7'h00, power_on_out_n_oe_o}, 8'h01);
    rdv(5'h00);
    chk(rv, 8'h02);
    rdv(A_FLAGS);
    chk(rv, 8'hA0);
    wait_on(0, 1'b0, 6);
    chk({7'h00, power_on_out_n_oe_o}, 8'h00);
    wt(2 * TICK);
    chk({7'h00, irq_oe_o}, 8'h00);
    // Undefined mask, outputs disabled
    put(A_AL_SEC, 8'h82);
    put(5'h09, 8'h00);
    put(A_CTRL, 8'h80);
    rdv(A_FLAGS);
    wt(TICK + 6);
    chk({7'h00, irq_oe_o}, 8'h00);
    chk({7'h00, power_on_out_n_oe_o}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      rdv(A_FLAGS);
      chk(rv & 8'h20, 8'h20);
      wt(TICK + 6);
    end
    // Supply failure blocks access and holds reset
    main_supply_ok_i = 1'b0;
    wt(3);
    chk({7'h00, reset_oe_o}, 8'h01);
    chk({7'h00, ext_mem_enable_out_n_o}, 8'h01);
    host.wr(A_AL_DAY, 8'h55, 1'b1, 1'b0);
    chk({7'h00, host.oe_seen}, 8'h00);
    main_supply_ok_i = 1'b1;
    wt(HOLD - 3);
    chk({7'h00, reset_oe_o}, 8'h01);
    wait_on(1, 1'b0, 8);
    rdv(A_AL_DAY);
    chk(rv, 8'h80);
    // Day match, raised while running from battery
    put(A_CTRL, 8'h40);
    for (int i = 0; i < 3; i++)
      put(i[4:0], 8'h00);
    put(5'h03, 8'h03);
    put(A_AL_SEC, 8'h01);
    put(5'h09, 8'h00);
    put(5'h0A, 8'h00);
    put(A_AL_DAY, 8'h43);
    rdv(A_FLAGS);
    put(A_CTRL, 8'h82);
    chk({7'h00, power_on_out_n_oe_o}, 8'h00);
    main_supply_ok_i = 1'b0;
    wait_on(2, 1'b1, 4 * TICK);
    chk({7'h00, irq_oe_o}, 8'h00);
    main_supply_ok_i = 1'b1;
    wait_on(1, 1'b0, HOLD + 4);
    rdv(A_FLAGS);
    chk(rv, 8'h20);
    end_of_test();
  end
endmodule
